// *** rtl/iras_pkg.sv ***
// Constants and types shared by the two-wire register access slave.
// Assumes a core clock domain plus a fast free-running link sampling clock.
// Summary of operation
// - Answer only at channel address 0xB2.
// - Frame: start, address, three address, three data.
// - Address and data bytes travel high byte first.
// - Repeated start, read address, three data returned.
// - Device pulls SDA low after each written byte of the frame.
// - Top address byte selects space, rest location.
// - Audio parameters live in address space zero.
// - Works at standard and fast bus rates.
// - Device acts only as a bus slave.
package iras_pkg;

	localparam logic [7:0]  CHAN_ADDR   = 8'hb2;     // Channel address, write form.
	localparam logic [7:0]  SPACE_AUDIO = 8'h00;     // Selector of the parameter space.
	localparam logic [2:0]  LAST_ADDR   = 3'h2;      // Index of the last address byte.
	localparam logic [2:0]  LAST_DATA   = 3'h5;      // Index of the last data byte.
	localparam logic [2:0]  FRAME_BYTES = 3'h6;      // Bytes after the device address.
	localparam logic [3:0]  BIT_ACK     = 4'h8;      // Bit count at the acknowledge slot.
	localparam logic [1:0]  TX_BYTES    = 2'h3;      // Data bytes returned by a read.
	localparam logic [23:0] WORD_RESET  = 24'h000000; // Value of unmapped locations.
	localparam int          LOC_DEPTH   = 256;       // Default locations in space zero.

	// Link side protocol states.
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_WAIT
	} iras_state_type;

endpackage

// *** rtl/iras_sync.sv ***
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input is stable long enough to be seen by the destination clock.
`timescale 1ns/1ps
module iras_sync #(
	parameter int W = 1 // Number of independent bits.
) (
	// Destination clock.
	input  wire logic         clk_in,
	// Asynchronous bits and their synchronised copy.
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	// The first stage feeds only the second stage.
	typedef struct packed {
		logic [W-1:0] s1; // Metastable catcher.
		logic [W-1:0] s2; // Settled copy.
	} iras_sync_type;

	iras_sync_type s_reg;  // Registered state.
	iras_sync_type s_next; // Next state.

	if (W < 1) begin : g_chk
		$error("iras_sync needs at least one bit.");
	end

	// No reset: the reset itself passes through one of these.
	always_comb begin
		s_next    = s_reg;
		s_next.s1 = d_in;
		s_next.s2 = s_reg.s1;
	end

	// Register the two stages.
	always_ff @(posedge clk_in) begin
		s_reg <= s_next;
	end

	assign q_out = s_reg.s2;

endmodule

// *** rtl/iras_top.sv ***
// Two-wire register access slave with a core-side parameter store.
// Assumes link_clk_in runs free and far faster than the bus clock, and that
// SDA and SCL are resolved outside from sda_oe_out as an open-drain wire.
`timescale 1ns/1ps
module iras_top #(
	parameter int LOC_DEPTH = iras_pkg::LOC_DEPTH // Locations held in space zero.
) (
	// Core clock and reset.
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// Link sampling clock.
	input  wire logic        link_clk_in,
	// Bus pins.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// Completed register writes, core domain.
	output logic             wr_pulse_out,
	output logic [23:0]      wr_addr_out,
	output logic [23:0]      wr_data_out
);

	localparam int         IDXW    = $clog2(LOC_DEPTH);   // Location index width.
	localparam logic [1:0] TX_LAST = iras_pkg::TX_BYTES;  // Index past the last read byte.

	if (LOC_DEPTH < 2 || LOC_DEPTH > 32768 || (LOC_DEPTH & (LOC_DEPTH - 1)) != 0) begin : g_chk
		$error("LOC_DEPTH must be a power of two from 2 to 32768.");
	end

	// Link side state.
	typedef struct packed {
		iras_pkg::iras_state_type st; // Protocol state.
		logic        scl_q;   // Previous synchronised SCL.
		logic        sda_q;   // Previous synchronised SDA.
		logic [3:0]  bitcnt;  // SCL rises seen in this byte.
		logic [7:0]  sh;      // Byte shifter.
		logic [2:0]  bytecnt; // Bytes taken after the device address.
		logic [1:0]  txcnt;   // Bytes handed out in a read.
		logic        rd_mode; // Direction bit of the last matched address.
		logic [23:0] raddr;   // Register address, held for the core.
		logic [23:0] wdata;   // Write data, held for the core.
		logic [23:0] rbuf;    // Read data returned by the core.
		logic        req_tgl; // Request toggle to the core.
		logic        req_wr;  // Request is a write.
		logic        ack_seen; // Last core answer toggle taken.
		logic        sda_oe;  // Pull SDA low.
	} iras_link_type;

	// Core side state.
	typedef struct packed {
		logic        seen;     // Last request toggle served.
		logic        ack_tgl;  // Answer toggle to the link.
		logic [23:0] rdata;    // Read result, stable once answered.
		logic        wr_pulse; // One cycle per write that lands in the store.
		logic [23:0] wr_addr;  // Address of that write.
		logic [23:0] wr_data;  // Data of that write.
	} iras_core_type;

	iras_link_type lr;        // Link registered state.
	iras_link_type ln;        // Link next state.
	iras_core_type cr;        // Core registered state.
	iras_core_type cn;        // Core next state.
	logic [23:0]   mem [LOC_DEPTH]; // Space zero parameter store.
	logic          mem_we;    // Store write this cycle.
	logic [2:0]    lsync;     // Synchronised SCL, SDA and answer toggle.
	logic          lrst;      // Reset as seen by the link clock.
	logic          req_s;     // Synchronised request toggle.
	logic          scl_s;     // Settled SCL.
	logic          sda_s;     // Settled SDA.
	logic          ack_s;     // Settled answer toggle.
	logic          scl_rise;  // SCL rising edge.
	logic          scl_fall;  // SCL falling edge.
	logic          start_c;   // Start or repeated start.
	logic          stop_c;    // Stop condition.
	logic          hit;       // Request falls inside the store.
	logic [7:0]    tx_byte;   // Next byte to return.

	// Pins pass two flops; the fast sampling keeps both bus rates in reach.
	iras_sync #(.W(3)) u_lsync (
		.clk_in (link_clk_in),
		.d_in   ({scl_in, sda_in, cr.ack_tgl}),
		.q_out  (lsync)
	);

	// Reset level moved into the link domain.
	iras_sync #(.W(1)) u_rsync (
		.clk_in (link_clk_in),
		.d_in   (srst_in),
		.q_out  (lrst)
	);

	// Request toggle moved into the core domain.
	iras_sync #(.W(1)) u_qsync (
		.clk_in (clk_in),
		.d_in   (lr.req_tgl),
		.q_out  (req_s)
	);

	assign scl_s    = lsync[2];
	assign sda_s    = lsync[1];
	assign ack_s    = lsync[0];
	assign scl_rise = scl_s & ~lr.scl_q;
	assign scl_fall = ~scl_s & lr.scl_q;
	assign start_c  = scl_s & lr.scl_q & lr.sda_q & ~sda_s;
	assign stop_c   = scl_s & lr.scl_q & ~lr.sda_q & sda_s;

	// Read bytes go out high byte first; extra bytes read as zero.
	always_comb begin
		case (lr.txcnt)
			2'h0:    tx_byte = lr.rbuf[23:16];
			2'h1:    tx_byte = lr.rbuf[15:8];
			2'h2:    tx_byte = lr.rbuf[7:0];
			default: tx_byte = 8'h00;
		endcase
	end

	// Link protocol engine. Start wins over everything, so a new frame always
	// recovers a confused slave.
	always_comb begin
		ln       = lr;
		ln.scl_q = scl_s;
		ln.sda_q = sda_s;
		// Core answer arrived: its read word is stable and safe to copy.
		if (ack_s != lr.ack_seen) begin
			ln.ack_seen = ack_s;
			ln.rbuf     = cr.rdata;
		end
		if (start_c) begin
			ln.st      = iras_pkg::ST_ADDR;
			ln.bitcnt  = 4'h0;
			ln.bytecnt = 3'h0;
			ln.txcnt   = 2'h0;
			ln.sda_oe  = 1'b0;
		end else if (stop_c) begin
			ln.st     = iras_pkg::ST_IDLE;
			ln.sda_oe = 1'b0;
		end else begin
			case (lr.st)
				iras_pkg::ST_ADDR, iras_pkg::ST_RX: begin
					if (scl_rise && lr.bitcnt < iras_pkg::BIT_ACK) begin
						ln.sh     = {lr.sh[6:0], sda_s};
						ln.bitcnt = lr.bitcnt + 4'h1;
					end else if (scl_fall && lr.bitcnt == iras_pkg::BIT_ACK) begin
						if (lr.st == iras_pkg::ST_ADDR) begin
							// Match the channel address, else stay silent.
							if (lr.sh[7:1] == iras_pkg::CHAN_ADDR[7:1]) begin
								ln.rd_mode = lr.sh[0];
								ln.sda_oe  = 1'b1;
								ln.st      = iras_pkg::ST_ACK;
							end else begin
								ln.st = iras_pkg::ST_WAIT;
							end
						end else if (lr.bytecnt < iras_pkg::FRAME_BYTES) begin
							ln.sda_oe  = 1'b1;
							ln.st      = iras_pkg::ST_ACK;
							ln.bytecnt = lr.bytecnt + 3'h1;
							// Bytes shift in from the top down.
							if (lr.bytecnt <= iras_pkg::LAST_ADDR) begin
								ln.raddr = {lr.raddr[15:0], lr.sh};
							end else begin
								ln.wdata = {lr.wdata[15:0], lr.sh};
							end
							// Address complete: fetch now so a read finds it ready.
							if (lr.bytecnt == iras_pkg::LAST_ADDR) begin
								ln.req_tgl = ~lr.req_tgl;
								ln.req_wr  = 1'b0;
							end
							// Only the last data byte commits the write.
							if (lr.bytecnt == iras_pkg::LAST_DATA) begin
								ln.req_tgl = ~lr.req_tgl;
								ln.req_wr  = 1'b1;
							end
						end else begin
							// Bytes past the frame are refused.
							ln.st = iras_pkg::ST_WAIT;
						end
					end
				end
				iras_pkg::ST_ACK, iras_pkg::ST_MACK: begin
					if (lr.st == iras_pkg::ST_MACK && scl_rise && sda_s) begin
						// Master refused the byte: the read is over.
						ln.st = iras_pkg::ST_WAIT;
					end else if (scl_fall) begin
						ln.bitcnt = 4'h0;
						if (lr.rd_mode) begin
							ln.st     = iras_pkg::ST_TX;
							ln.sh     = tx_byte;
							ln.sda_oe = ~tx_byte[7];
							if (lr.txcnt != TX_LAST) begin
								ln.txcnt = lr.txcnt + 2'h1;
							end
						end else begin
							ln.st     = iras_pkg::ST_RX;
							ln.sda_oe = 1'b0; // Release after one bit period.
						end
					end
				end
				iras_pkg::ST_TX: begin
					if (scl_rise) begin
						ln.bitcnt = lr.bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (lr.bitcnt == iras_pkg::BIT_ACK) begin
							ln.sda_oe = 1'b0; // Let the master answer.
							ln.st     = iras_pkg::ST_MACK;
						end else begin
							ln.sh     = {lr.sh[6:0], 1'b0};
							ln.sda_oe = ~lr.sh[6];
						end
					end
				end
				default: begin
					// Idle or ignoring: SDA stays released until a start.
					ln.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// Link state register.
	always_ff @(posedge link_clk_in) begin
		if (lrst) begin
			lr <= '0;
		end else begin
			lr <= ln;
		end
	end

	// Requests land in space zero only, inside the store.
	assign hit = (lr.raddr[23:16] == iras_pkg::SPACE_AUDIO) &&
	             (lr.raddr[15:IDXW] == '0);

	// Core service: link fields are stable while a request toggle is pending.
	always_comb begin
		cn          = cr;
		cn.wr_pulse = 1'b0;
		mem_we      = 1'b0;
		if (req_s != cr.seen) begin
			cn.seen    = req_s;
			cn.ack_tgl = ~cr.ack_tgl;
			if (lr.req_wr) begin
				if (hit) begin
					mem_we      = 1'b1;
					cn.wr_pulse = 1'b1;
					cn.wr_addr  = lr.raddr;
					cn.wr_data  = lr.wdata;
				end
			end else begin
				cn.rdata = hit ? mem[lr.raddr[IDXW-1:0]] : iras_pkg::WORD_RESET;
			end
		end
	end

	// Core state register.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cr <= '0;
		end else begin
			cr <= cn;
		end
	end

	// Parameter store; contents are undefined until written.
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[lr.raddr[IDXW-1:0]] <= lr.wdata;
		end
	end

	// Open drain: the pin level is always low when driven.
	assign sda_out      = 1'b0;
	assign sda_oe_out   = lr.sda_oe;
	assign wr_pulse_out = cr.wr_pulse;
	assign wr_addr_out  = cr.wr_addr;
	assign wr_data_out  = cr.wr_data;

	// End of a received byte, before the acknowledge slot.
	sequence s_addr_end;
		lr.st == iras_pkg::ST_ADDR && scl_fall && lr.bitcnt == iras_pkg::BIT_ACK;
	endsequence
	sequence s_rx_end;
		lr.st == iras_pkg::ST_RX && scl_fall && lr.bitcnt == iras_pkg::BIT_ACK;
	endsequence

	a_addr_match: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_addr_end ##0 (lr.sh[7:1] == iras_pkg::CHAN_ADDR[7:1])
		|=> sda_oe_out && lr.st == iras_pkg::ST_ACK)
		else $error("Own address byte was not acknowledged.");

	a_foreign_quiet: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_addr_end ##0 (lr.sh[7:1] != iras_pkg::CHAN_ADDR[7:1])
		|=> (!sda_oe_out && lr.st == iras_pkg::ST_WAIT)[*2])
		else $error("Foreign address byte was answered.");

	a_byte_acked: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_rx_end ##0 (lr.bytecnt < iras_pkg::FRAME_BYTES) |=> sda_oe_out)
		else $error("Written byte was not acknowledged.");

	a_ack_release: assert property (@(posedge link_clk_in) disable iff (lrst)
		(lr.st == iras_pkg::ST_ACK && !lr.rd_mode && scl_fall && !start_c)
		|=> !sda_oe_out && lr.st == iras_pkg::ST_RX)
		else $error("Acknowledge held past its bit period.");

	a_read_fetch: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_rx_end ##0 (lr.bytecnt == iras_pkg::LAST_ADDR)
		|=> !lr.req_wr && lr.req_tgl != $past(lr.req_tgl) && lr.raddr[7:0] == $past(lr.sh))
		else $error("Address completion did not fetch the register.");

	a_write_commit: assert property (@(posedge link_clk_in) disable iff (lrst)
		s_rx_end ##0 (lr.bytecnt == iras_pkg::LAST_DATA)
		|=> lr.req_wr && lr.req_tgl != $past(lr.req_tgl) && lr.wdata[7:0] == $past(lr.sh))
		else $error("Last data byte did not commit the write.");

	a_no_partial: assert property (@(posedge link_clk_in) disable iff (lrst)
		(lr.st != iras_pkg::ST_RX || !scl_fall || lr.bitcnt != iras_pkg::BIT_ACK)
		|=> $stable(lr.req_tgl))
		else $error("Request raised outside a byte boundary.");

	a_nack_ends: assert property (@(posedge link_clk_in) disable iff (lrst)
		(lr.st == iras_pkg::ST_MACK && scl_rise && sda_s)
		|=> lr.st == iras_pkg::ST_WAIT && !sda_oe_out)
		else $error("Read continued after a refused byte.");

	a_slave_only: assert property (@(posedge link_clk_in) disable iff (lrst)
		sda_oe_out |-> lr.st inside {iras_pkg::ST_ACK, iras_pkg::ST_TX})
		else $error("SDA driven outside an answer slot.");

	a_space_zero: assert property (@(posedge clk_in) disable iff (srst_in)
		wr_pulse_out |-> wr_addr_out[23:16] == iras_pkg::SPACE_AUDIO &&
		$past(cr.ack_tgl) != cr.ack_tgl)
		else $error("Write landed outside space zero.");

endmodule

// *** sim/iras_master_model.sv ***
// Behavioural two-wire bus master that drives register frames at the slave.
// Assumes the bench resolves both lines as open-drain wires with pull-ups.
`timescale 1ns/1ps
module iras_master_model (
	// Core clock, used only as the timing base.
	input  wire logic clk_in,
	// Resolved bus levels.
	input  wire logic scl_in,
	input  wire logic sda_in,
	// High while the master pulls a line low.
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	int hq = 7; // Quarter bit in core cycles; 7 gives about 357 kHz.

	// The bus starts released, so the slave sees an idle line after boot.
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// Waits a quarter bit; stepping on falling edges keeps us off the sampling edge.
	task automatic quarter();
		repeat (hq) @(negedge clk_in);
	endtask

	// Clocks one bit and returns the level seen in the middle of SCL high.
	task automatic bit_io(input logic b, output logic seen);
		sda_oe_out = ~b;
		quarter();
		scl_oe_out = 1'b0;
		quarter();
		seen = sda_in;
		quarter();
		scl_oe_out = 1'b1;
		quarter();
	endtask

	// Start or repeated start; SCL is left low afterwards.
	task automatic start();
		sda_oe_out = 1'b0;
		quarter();
		scl_oe_out = 1'b0;
		quarter();
		sda_oe_out = 1'b1;
		quarter();
		scl_oe_out = 1'b1;
		quarter();
	endtask

	// Stop: SDA rises while SCL is high, then the bus is left idle.
	task automatic stop();
		sda_oe_out = 1'b1;
		quarter();
		scl_oe_out = 1'b0;
		quarter();
		sda_oe_out = 1'b0;
		quarter();
	endtask

	// Sends a byte high bit first; ack is high when the slave pulled SDA low.
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// Receives a byte, then answers with an ack, or a nack on the last one.
	task automatic rbyte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			v[i] = s;
		end
		bit_io(last, s);
	endtask

	// Write frame with nd data bytes; a fourth data byte probes the frame limit.
	task automatic write_frame(input logic [7:0] dev, input logic [23:0] a, d,
			input int nd, output logic [7:0] acks);
		logic [47:0] f;
		logic        k;
		f    = {a, d};
		acks = 8'h00;
		start();
		wbyte(dev, k);
		acks[0] = k;
		for (int i = 0; i < 3 + nd; i++) begin
			wbyte((i < 6) ? f[47 - 8 * i -: 8] : 8'h5a, k);
			acks[i + 1] = k;
		end
		stop();
	endtask

	// Read: dummy write of the address, repeated start, then three bytes back.
	task automatic read_frame(input logic [7:0] dev, input logic [23:0] a,
			output logic [23:0] d, output logic [4:0] acks);
		logic       k;
		logic [7:0] v;
		start();
		wbyte(dev, k);
		acks[0] = k;
		for (int i = 0; i < 3; i++) begin
			wbyte(a[23 - 8 * i -: 8], k);
			acks[i + 1] = k;
		end
		start();
		wbyte(dev | 8'h01, k);
		acks[4] = k;
		for (int i = 0; i < 3; i++) begin
			rbyte(i == 2, v);
			d[23 - 8 * i -: 8] = v;
		end
		stop();
	endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the register access slave.
// Assumes the master model above and open-drain wires resolved here.
`timescale 1ns/1ps
module tb_top;
	localparam int DEPTH = 16; // Small store so the top location is easy to reach.
	logic        clk_in, srst_in, link_clk_in;
	logic        scl_w, sda_w, scl_oe_m, sda_oe_m, sda_oe_d, sda_d, wr_pulse;
	logic [23:0] wr_a, wr_d, pulse_a, pulse_d;
	int          errors, samples_checked, pulses;

	// Both lines have pull-ups; any party pulling low wins.
	assign scl_w = ~scl_oe_m;
	assign sda_w = ~(sda_oe_m | sda_oe_d);

	iras_top #(.LOC_DEPTH(DEPTH)) dut (.clk_in(clk_in), .srst_in(srst_in),
		.link_clk_in(link_clk_in), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_d),
		.sda_oe_out(sda_oe_d), .wr_pulse_out(wr_pulse), .wr_addr_out(wr_a),
		.wr_data_out(wr_d));
	iras_master_model m (.clk_in(clk_in), .scl_in(scl_w), .sda_in(sda_w),
		.scl_oe_out(scl_oe_m), .sda_oe_out(sda_oe_m));

	// Core clock at 10 MHz; link clock at 12 ns with an unrelated phase.
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		link_clk_in = 1'b0;
		#3.7;
		forever #6 link_clk_in = ~link_clk_in;
	end

	// Counts committed writes and keeps what each one carried.
	always @(posedge clk_in) begin
		if (wr_pulse === 1'b1) begin
			pulses++;
			pulse_a = wr_a;
			pulse_d = wr_d;
		end
	end

	// Compares one value and reports a difference at once.
	task automatic check(input logic [47:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic close_out();
		if (errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// One write frame, judged by its acknowledges and the commit it causes.
	task automatic do_write(input logic [7:0] dev, input logic [23:0] a, d, input int nd,
			input logic [7:0] ex_acks, input int ex_p);
		logic [7:0] acks;
		int         p0;
		p0 = pulses;
		m.write_frame(dev, a, d, nd, acks);
		repeat (10) @(negedge clk_in);
		check(48'(acks), 48'(ex_acks));
		check(48'(pulses - p0), 48'(ex_p));
		if (ex_p == 1) check({pulse_a, pulse_d}, {a, d});
	endtask

	// One read frame, judged by its acknowledges and the word returned.
	task automatic do_read(input logic [7:0] dev, input logic [23:0] a, exp,
			input logic [4:0] ex_acks);
		logic [23:0] d;
		logic [4:0]  acks;
		m.read_frame(dev, a, d, acks);
		check(48'(acks), 48'(ex_acks));
		if (ex_acks == 5'h1f) check(48'(d), 48'(exp));
	endtask

	// Outputs after reset are quiet and cleared.
	task automatic t_reset();
		// The data pin, its enable and the write strobe are all quiet after reset.
		check(48'({sda_oe_d, sda_d, wr_pulse}), 48'h0);
		check({wr_a, wr_d}, 48'h0);
	endtask

	// Writes at both ends of the store, then reads each word back.
	task automatic t_write_read();
		do_write(8'hb2, 24'h000000, 24'ha5c3f0, 3, 8'h7f, 1);
		do_write(8'hb2, 24'h00000f, 24'h123456, 3, 8'h7f, 1);
		do_write(8'hb2, 24'h000007, 24'hfedcba, 3, 8'h7f, 1);
		do_read(8'hb2, 24'h000000, 24'ha5c3f0, 5'h1f);
		do_read(8'hb2, 24'h00000f, 24'h123456, 5'h1f);
		do_read(8'hb2, 24'h000007, 24'hfedcba, 5'h1f);
	endtask

	// A foreign device address draws no answer and changes nothing.
	task automatic t_foreign();
		do_write(8'hb4, 24'h000007, 24'h111111, 3, 8'h00, 0);
		do_read(8'hb4, 24'h000007, 24'h0, 5'h00);
		do_read(8'hb2, 24'h000007, 24'hfedcba, 5'h1f);
	endtask

	// Stop after two data bytes leaves the word as it was.
	task automatic t_partial();
		do_write(8'hb2, 24'h000007, 24'h222222, 2, 8'h3f, 0);
		do_read(8'hb2, 24'h000007, 24'hfedcba, 5'h1f);
	endtask

	// Other spaces and locations past the store are acked but not written; space one reads as zero.
	task automatic t_out_space();
		do_write(8'hb2, 24'h010007, 24'h333333, 3, 8'h7f, 0);
		do_write(8'hb2, 24'h000010, 24'h444444, 3, 8'h7f, 0);
		do_read(8'hb2, 24'h010007, 24'h000000, 5'h1f);
		do_read(8'hb2, 24'h000007, 24'hfedcba, 5'h1f);
	endtask

	// A byte past the frame is refused, but the frame itself still lands.
	task automatic t_extra();
		do_write(8'hb2, 24'h000003, 24'h0f0f0f, 4, 8'h7f, 1);
		do_read(8'hb2, 24'h000003, 24'h0f0f0f, 5'h1f);
	endtask

	// The same exchange at standard-mode speed.
	task automatic t_std_rate();
		m.hq = 25;
		do_write(8'hb2, 24'h000009, 24'h5a5a5a, 3, 8'h7f, 1);
		do_read(8'hb2, 24'h000009, 24'h5a5a5a, 5'h1f);
		m.hq = 7;
	endtask

	// Main sequence: reset, a quiet microsecond or two, then every scenario.
	initial begin
		srst_in         = 1'b1;
		errors          = 0;
		samples_checked = 0;
		pulses          = 0;
		repeat (5) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (20) @(negedge clk_in);
		t_reset();
		t_write_read();
		t_foreign();
		t_partial();
		t_out_space();
		t_extra();
		t_std_rate();
		close_out();
	end

	// Watchdog sized well above the expected run of about 50000 cycles.
	initial begin
		repeat (90000) @(posedge clk_in);
		errors++;
		close_out();
	end
endmodule
